// ===== dv/gdst_conv_model.sv
`timescale 1ns/1ns
module gdst_conv_model
  import gdst_pkg::*;
(
  input wire logic clock,
  input wire logic convRequest,
  output logic convDone,
  output logic [RESULT_W-1:0] convData
);
  int waitN;
  // answers after 0..5 idle cycles; released data is inverted so stale values never match
  initial begin
    convDone = 1'b0;
    convData = '0;
    forever begin
      @(posedge clock);
      #1;
      if (convRequest) begin
        waitN = $urandom_range(5);
        // every wait ends just after an edge so the answer never races the design's sampling edge
        repeat (waitN) begin
          @(posedge clock);
          #1;
        end
        convDone = 1'b1;
        convData = RESULT_W'($urandom);
        @(posedge clock);
        #1 convDone = 1'b0;
        convData = ~convData;
      end
    end
  end
endmodule

// ===== dv/gdst_regs_sva.sv
`timescale 1ns/1ns
module gdst_regs_sva
  import gdst_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic regWrite,
  input wire logic [DATA_W-1:0] regWriteData,
  input wire logic configIntegrityMismatch,
  input wire logic inConfig2,
  input wire gdst_comp_t comparatorFault,
  input wire logic secondaryConfigIntegrityFault,
  input wire logic gateThresholdMeasureRun,
  input wire logic convDone,
  input wire logic [RESULT_W-1:0] convData,
  input wire logic convRequest,
  input wire logic [2:0] convSlot,
  input wire logic [SLOT_COUNT-1:0][RESULT_W-1:0] convResults
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic stWr;
  assign stWr = regWrite && regAddr == SELFTEST_CONTROL_ADDR;
  a_sat_forced:
    assert property (stWr && regWriteData[9] |=> comparatorFault.saturation) else $error("no sat fault");
  a_short_forced:
    assert property (stWr && regWriteData[8] |=> comparatorFault.shortCircuit) else $error("no short fault");
  a_over_forced:
    assert property (stWr && regWriteData[7] |=> comparatorFault.overcurrent) else $error("no over fault");
  a_clock_forced:
    assert property (stWr && regWriteData[3] |=> comparatorFault.clockMonitor) else $error("no clock fault");
  a_thermal_forced:
    assert property (stWr && regWriteData[1] |=> comparatorFault.switchThermal) else $error("no thermal fault");
  a_threshold_gated:
    assert property (gateThresholdMeasureRun |-> inConfig2) else $error("threshold run outside config2");
  a_integrity_fault:
    assert property (stWr && regWriteData[2] ##1 configIntegrityMismatch |-> secondaryConfigIntegrityFault)
      else $error("no integrity fault");
  a_result_stored:
    assert property (convRequest && convDone |=> convResults[$past(convSlot)] == $past(convData))
      else $error("result slot wrong");
  a_request_held:
    assert property (convRequest && !convDone |=> convRequest && $stable(convSlot)) else $error("request dropped");
endmodule
bind gdst_regs gdst_regs_sva sva (.clock, .reset, .regAddr, .regWrite, .regWriteData, .configIntegrityMismatch,
  .inConfig2, .comparatorFault, .secondaryConfigIntegrityFault, .gateThresholdMeasureRun, .convDone, .convData,
  .convRequest, .convSlot, .convResults);

// ===== dv/test_gdst_regs.sv
`timescale 1ns/1ns
module test_gdst_regs import gdst_pkg::*;;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic regWrite = 1'b0, regRead = 1'b0, configIntegrityMismatch = 1'b0, inConfig2 = 1'b0, pwmOn = 1'b0;
  logic [DATA_W-1:0] regWriteData = '0, regReadData, rv, d;
  gdst_comp_t comparatorRaw = '0, comparatorFault;
  logic secondaryConfigIntegrityFault, gateThresholdMeasureRun, convDone, convRequest, pulseOutputActive, pulsePeriodTick;
  logic [RESULT_W-1:0] convData;
  logic [2:0] convSlot, overtempEnable, overcurrentEnable, pulseOutputSource, lastSlot;
  logic [1:0] pulseOutputFrequency;
  logic [SLOT_COUNT-1:0][RESULT_W-1:0] convResults, expRes;
  logic [6:0] en;
  logic mon = 1'b0;
  int errors = 0, nChecks = 0, nDone, k;
  always #20 clock = ~clock;
  gdst_regs uut (.clock, .reset, .regAddr, .regWrite, .regWriteData, .regRead, .regReadData, .comparatorRaw,
    .configIntegrityMismatch, .inConfig2, .comparatorFault, .secondaryConfigIntegrityFault, .gateThresholdMeasureRun,
    .pwmOn, .convDone, .convData, .convRequest, .convSlot, .convResults, .overtempEnable, .overcurrentEnable,
    .pulseOutputFrequency, .pulseOutputActive, .pulseOutputSource, .pulsePeriodTick);
  gdst_conv_model conv (.clock, .convRequest, .convDone, .convData);
  function automatic logic [2:0] nextSlot(logic [2:0] last, logic [6:0] e);
    nextSlot = last;
    for (int i = 7; i >= 1; i--) if (e[(last + i) % 7]) nextSlot = 3'((last + i) % 7);
  endfunction
  function automatic logic [2:0] lowest(logic [6:0] e);
    lowest = '0;
    for (int i = 6; i >= 0; i--) if (e[i]) lowest = 3'(i);
  endfunction
  function automatic int periodOf(logic [1:0] c);
    periodOf = CLOCK_HZ / (c == 2'h0 ? PULSE_FREQ_0_HZ : c == 2'h1 ? PULSE_FREQ_1_HZ :
      c == 2'h2 ? PULSE_FREQ_2_HZ : PULSE_FREQ_3_HZ);
  endfunction
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    nChecks++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] v);
    step();
    regAddr = a;
    regWrite = 1'b1;
    regWriteData = v;
    step();
    regWrite = 1'b0;
    regWriteData = ~v;
  endtask
  task automatic rd(logic [ADDR_W-1:0] a);
    step();
    regAddr = a;
    regRead = 1'b1;
    step();
    regRead = 1'b0;
    rv = regReadData;
  endtask
  task automatic pulseCheck(logic [15:0] v);
    wr(PULSE_CONFIG_ADDR, v);
    chk("overtemp", 16'(v[15:13]), 16'(overtempEnable));
    chk("overcurrent", 16'(v[12:10]), 16'(overcurrentEnable));
    chk("frequency", 16'(v[9:8]), 16'(pulseOutputFrequency));
    chk("active", 16'(|v[6:0]), 16'(pulseOutputActive));
    if (|v[6:0]) chk("source", 16'(lowest(v[6:0])), 16'(pulseOutputSource));
  endtask
  // measures from one tick to the next, so the first tick after the write may be irregular
  task automatic periodCheck(logic [1:0] c);
    int n;
    wr(PULSE_CONFIG_ADDR, {6'h06, c, 8'h00});
    for (n = 0; n < 4000 && !pulsePeriodTick; n++) step();
    step();
    for (n = 1; n < 4000 && !pulsePeriodTick; n++) step();
    chk("tick period", 16'(periodOf(c)), 16'(n));
  endtask
  task automatic test_done();
    if (errors == 0 && nChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----------
  // converter monitor
  // ----------
  // sampled mid-cycle, where request, slot and answer are all settled
  always @(negedge clock) begin
    if (mon && convRequest && convDone) begin
      chk("slot", 16'(nextSlot(lastSlot, en)), 16'(convSlot));
      lastSlot = convSlot;
      expRes[convSlot] = convData;
      nDone++;
    end
  end
  initial begin
    void'($urandom(3));
    repeat (12) @(posedge clock);
    #1 reset = 1'b0;
    rd(PULSE_CONFIG_ADDR);
    chk("pulse reset", 16'h1800, rv);
    chk("oc reset", 16'h0006, 16'(overcurrentEnable));
    pwmOn = 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr(SELFTEST_CONTROL_ADDR, 16'h0001 << (i < 3 ? 9 - i : 9 - 2 * i));
      chk("forced fault", 16'(5'h10 >> i), 16'(comparatorFault));
      rd(SELFTEST_CONTROL_ADDR);
      chk("access during test", 16'h0001 << (i < 3 ? 9 - i : 9 - 2 * i), rv);
    end
    configIntegrityMismatch = 1'b1;
    wr(SELFTEST_CONTROL_ADDR, 16'h0024);
    chk("integrity", 16'h0001, 16'(secondaryConfigIntegrityFault));
    chk("run outside", 16'h0000, 16'(gateThresholdMeasureRun));
    inConfig2 = 1'b1;
    step();
    chk("run inside", 16'h0001, 16'(gateThresholdMeasureRun));
    configIntegrityMismatch = 1'b0;
    step();
    chk("integrity idle", 16'h0000, 16'(secondaryConfigIntegrityFault));
    wr(SELFTEST_CONTROL_ADDR, 16'h0000);
    chk("faults cleared", 16'h0000, 16'(comparatorFault));
    comparatorRaw = gdst_comp_t'(5'h15);
    step();
    comparatorRaw = '0;
    repeat (4) step();
    chk("glitch filtered", 16'h0000, 16'(comparatorFault));
    d = 16'($urandom) | 16'h0001;
    comparatorRaw = gdst_comp_t'(d[4:0]);
    repeat (4) step();
    chk("comparator level", 16'(d[4:0]), 16'(comparatorFault));
    comparatorRaw = '0;
    repeat (4) step();
    chk("comparator quiet", 16'h0000, 16'(comparatorFault));
    for (int j = 0; j < 8; j++) pulseCheck({6'h2a, 2'(j), 8'(8'h81 << j)});
    for (int j = 0; j < 4; j++) periodCheck(2'(j));
    for (int i = 0; i < 30; i++) begin
      k = $urandom_range(3);
      d = 16'($urandom);
      wr(6'h0d + 6'(k), d);
      rd(6'h0d + 6'(k));
      chk("readback", d & (k == 3 ? 16'h0 : k == 2 ? 16'hff7f : k == 1 ? 16'h7f7f : 16'h03ae), rv);
      if (k == 2) pulseCheck(d);
    end
    for (int ph = 0; ph < 2; ph++) begin
      mon = 1'b0;
      reset = 1'b1;
      repeat (12) @(posedge clock);
      #1 reset = 1'b0;
      en = ph == 0 ? 7'($urandom) | 7'h41 : 7'h10;
      pwmOn = ph == 0;
      lastSlot = 3'h6;
      nDone = 0;
      mon = 1'b1;
      wr(CONVERTER_CONFIG_ADDR, ph == 0 ? {1'b0, en, 1'b0, ~en} : {1'b0, ~en, 1'b0, en});
      for (k = 0; k < 3000 && nDone < 16; k++) step();
      chk("conversions", 16'h0001, 16'(nDone >= 16));
      if (nDone < 16) test_done();
      for (int s = 0; s < 7; s++) if (en[s]) chk("result", 16'(expRes[s]), 16'(convResults[s]));
    end
    test_done();
  end
endmodule

// ===== rtl/gdst_pkg.sv
// Notes on behaviour
// (RULE1) saturation self-test bit 9 forces the saturation comparator fault.
// (RULE2) short-circuit self-test bit 8 forces the short-circuit comparator fault.
// (RULE3) overcurrent self-test bit 7 forces the overcurrent comparator fault.
// (RULE4) host must be active, check disabled, high output driven on before these tests.
// (RULE5) host clears the configuration-check disable bit after latent tests.
// (RULE6) bit 5 starts threshold measurement, honoured only in second configuration state.
// (RULE7) bit 3 forces a secondary clock monitor fault; register access keeps working.
// (RULE8) bit 2 runs the secondary configuration check; failure raises its fault.
// (RULE9) bit 1 forces the switch over-temperature protection fault.
// (RULE10) converter bits 14..8 enable on-phase channels; bit 15 reserved.
// (RULE11) converter bits 6..0 enable off-phase channels; bit 7 reserved.
// (RULE12) round robin order one, three, five, two, four, six, die; skip disabled.
// (RULE13) results land in slots 1..7 following the round robin order.
// (RULE14) bits 15..13 enable over-temperature on inputs one, three, five; reset off.
// (RULE15) bits 12..10 enable overcurrent on inputs two, four, six; reset 1,1,0.
// (RULE16) bits 9..8 pick pulse output frequency 13.9, 27.8, 55.7, 111.4 kHz.
// (RULE17) bits 6..0 route one source to pulse output; host sets one only.
// (RULE18) reserved bits read zero and writes to them do nothing.
// (RULE19) several select bits set: lowest-numbered selected channel wins.
package gdst_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] SELFTEST_CONTROL_ADDR = 6'h0d;
  localparam logic [ADDR_W-1:0] CONVERTER_CONFIG_ADDR = 6'h0e;
  localparam logic [ADDR_W-1:0] PULSE_CONFIG_ADDR = 6'h0f;

  localparam logic [DATA_W-1:0] SELFTEST_CONTROL_MASK = 16'h03ae;
  localparam logic [DATA_W-1:0] CONVERTER_CONFIG_MASK = 16'h7f7f;
  localparam logic [DATA_W-1:0] PULSE_CONFIG_MASK = 16'hff7f;
  localparam logic [DATA_W-1:0] SELFTEST_CONTROL_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] CONVERTER_CONFIG_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] PULSE_CONFIG_RESET = 16'h1800;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SATURATION_DETECT_SELFTEST_BIT = 9;
  localparam int SHORT_CIRCUIT_SELFTEST_BIT = 8;
  localparam int OVERCURRENT_SELFTEST_BIT = 7;
  localparam int GATE_THRESHOLD_MEASURE_RUN_BIT = 5;
  localparam int SECONDARY_CLOCK_MONITOR_SELFTEST_BIT = 3;
  localparam int SECONDARY_CONFIG_INTEGRITY_CHECK_BIT = 2;
  localparam int SWITCH_THERMAL_SELFTEST_BIT = 1;
  localparam int ON_PHASE_CHANNEL_ENABLE_LSB = 8;
  localparam int OFF_PHASE_CHANNEL_ENABLE_LSB = 0;
  localparam int OVERTEMP_ENABLE_LSB = 13;
  localparam int OVERCURRENT_ENABLE_LSB = 10;
  localparam int PULSE_OUTPUT_FREQUENCY_LSB = 8;
  localparam int PULSE_OUTPUT_SELECT_LSB = 0;

  // ----------------------------------------------------------------
  // converter and pulse output
  // ----------------------------------------------------------------
  localparam int SLOT_COUNT = 7;
  localparam int RESULT_W = 10;
  localparam logic [2:0] LAST_SLOT = 3'h6;
  localparam int CLOCK_HZ = 25000000;
  localparam int PULSE_FREQ_0_HZ = 13900;
  localparam int PULSE_FREQ_1_HZ = 27800;
  localparam int PULSE_FREQ_2_HZ = 55700;
  localparam int PULSE_FREQ_3_HZ = 111400;
  localparam int PERIOD_W = 11;
  localparam logic [PERIOD_W-1:0] PULSE_PERIOD_0 = PERIOD_W'(CLOCK_HZ / PULSE_FREQ_0_HZ);
  localparam logic [PERIOD_W-1:0] PULSE_PERIOD_1 = PERIOD_W'(CLOCK_HZ / PULSE_FREQ_1_HZ);
  localparam logic [PERIOD_W-1:0] PULSE_PERIOD_2 = PERIOD_W'(CLOCK_HZ / PULSE_FREQ_2_HZ);
  localparam logic [PERIOD_W-1:0] PULSE_PERIOD_3 = PERIOD_W'(CLOCK_HZ / PULSE_FREQ_3_HZ);

  typedef enum logic {SEQ_IDLE, SEQ_CONVERT} gdst_seq_t;

  // comparator lines, bit order: sat, short, over, clock, thermal
  typedef struct packed {
    logic saturation;
    logic shortCircuit;
    logic overcurrent;
    logic clockMonitor;
    logic switchThermal;
  } gdst_comp_t;

  typedef struct packed {
    logic [DATA_W-1:0] selftestControl;
    logic [DATA_W-1:0] converterConfig;
    logic [DATA_W-1:0] pulseConfig;
    logic [DATA_W-1:0] readData;
    gdst_comp_t compSync1;
    gdst_comp_t compSync2;
    gdst_comp_t compSync3;
    gdst_comp_t compStable;
    gdst_seq_t seqState;
    logic [2:0] seqSlot;
    logic [SLOT_COUNT-1:0][RESULT_W-1:0] results;
    logic [PERIOD_W-1:0] periodCount;
    logic periodTick;
  } gdst_state_t;

endpackage

// ===== rtl/gdst_regs.sv
`timescale 1ns/1ns
module gdst_regs
  import gdst_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic regWrite,
  input wire logic [DATA_W-1:0] regWriteData,
  input wire logic regRead,
  output logic [DATA_W-1:0] regReadData,
  input wire gdst_comp_t comparatorRaw,
  input wire logic configIntegrityMismatch,
  input wire logic inConfig2,
  output gdst_comp_t comparatorFault,
  output logic secondaryConfigIntegrityFault,
  output logic gateThresholdMeasureRun,
  input wire logic pwmOn,
  input wire logic convDone,
  input wire logic [RESULT_W-1:0] convData,
  output logic convRequest,
  output logic [2:0] convSlot,
  output logic [SLOT_COUNT-1:0][RESULT_W-1:0] convResults,
  output logic [2:0] overtempEnable,
  output logic [2:0] overcurrentEnable,
  output logic [1:0] pulseOutputFrequency,
  output logic pulseOutputActive,
  output logic [2:0] pulseOutputSource,
  output logic pulsePeriodTick
);

  gdst_state_t st;
  gdst_state_t next_st;

  // ----------------------------------------------------------------
  // field views
  // ----------------------------------------------------------------
  logic [SLOT_COUNT-1:0] onEnable;
  logic [SLOT_COUNT-1:0] offEnable;
  logic [SLOT_COUNT-1:0] phaseEnable;
  logic [SLOT_COUNT-1:0] sourceSelect;
  logic [PERIOD_W-1:0] periodLength;
  logic [2:0] pickSlot;
  logic pickFound;
  logic [2:0] lowSource;
  logic lowFound;

  assign onEnable = st.converterConfig[ON_PHASE_CHANNEL_ENABLE_LSB +: SLOT_COUNT]; // RULE10
  assign offEnable = st.converterConfig[OFF_PHASE_CHANNEL_ENABLE_LSB +: SLOT_COUNT]; // RULE11
  assign phaseEnable = pwmOn ? onEnable : offEnable;
  assign sourceSelect = st.pulseConfig[PULSE_OUTPUT_SELECT_LSB +: SLOT_COUNT];

  // ----------------------------------------------------------------
  // round robin search
  // ----------------------------------------------------------------
  // slot index equals enable bit index, so the fixed visiting order is just ascending slots
  always_comb begin
    logic [3:0] cand;
    cand = 4'h0;
    pickSlot = 3'h0;
    pickFound = 1'b0;
    for (int i = 1; i <= SLOT_COUNT; i++) begin
      cand = 4'({1'b0, st.seqSlot} + 4'(i));
      if (cand >= 4'(SLOT_COUNT)) begin
        cand = cand - 4'(SLOT_COUNT);
      end
      if (!pickFound && phaseEnable[cand[2:0]]) begin
        pickFound = 1'b1; // RULE12
        pickSlot = cand[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // pulse output source
  // ----------------------------------------------------------------
  // a single set bit is expected; picking the lowest keeps the mux defined otherwise
  always_comb begin
    lowSource = 3'h0;
    lowFound = 1'b0;
    for (int i = SLOT_COUNT - 1; i >= 0; i--) begin
      if (sourceSelect[i]) begin
        lowFound = 1'b1; // RULE17
        lowSource = 3'(i); // RULE19
      end
    end
  end

  always_comb begin
    case (st.pulseConfig[PULSE_OUTPUT_FREQUENCY_LSB +: 2]) // RULE16
      2'h0: periodLength = PULSE_PERIOD_0;
      2'h1: periodLength = PULSE_PERIOD_1;
      2'h2: periodLength = PULSE_PERIOD_2;
      2'h3: periodLength = PULSE_PERIOD_3;
      default: periodLength = PULSE_PERIOD_0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.periodTick = 1'b0;

    // register port: access stays live during every self-test
    if (regWrite) begin
      case (regAddr)
        SELFTEST_CONTROL_ADDR: next_st.selftestControl = regWriteData & SELFTEST_CONTROL_MASK; // RULE18
        CONVERTER_CONFIG_ADDR: next_st.converterConfig = regWriteData & CONVERTER_CONFIG_MASK; // RULE18
        PULSE_CONFIG_ADDR: next_st.pulseConfig = regWriteData & PULSE_CONFIG_MASK; // RULE18
        default: next_st.selftestControl = st.selftestControl;
      endcase
    end
    if (regRead) begin
      case (regAddr)
        SELFTEST_CONTROL_ADDR: next_st.readData = st.selftestControl; // RULE7
        CONVERTER_CONFIG_ADDR: next_st.readData = st.converterConfig;
        PULSE_CONFIG_ADDR: next_st.readData = st.pulseConfig;
        default: next_st.readData = 16'h0000;
      endcase
    end

    // comparator lines come from the analog side, so filter through three stages
    next_st.compSync1 = comparatorRaw;
    next_st.compSync2 = st.compSync1;
    next_st.compSync3 = st.compSync2;
    if (st.compSync2 == st.compSync3) begin
      next_st.compStable = st.compSync3;
    end

    // converter sequencer
    case (st.seqState)
      SEQ_IDLE: begin
        if (pickFound) begin
          next_st.seqSlot = pickSlot;
          next_st.seqState = SEQ_CONVERT;
        end
      end
      SEQ_CONVERT: begin
        if (convDone) begin
          next_st.results[st.seqSlot] = convData; // RULE13
          next_st.seqState = SEQ_IDLE;
        end
      end
      default: next_st.seqState = SEQ_IDLE;
    endcase

    // pulse output carrier period
    if (st.periodCount >= periodLength - 11'h001) begin
      next_st.periodCount = 11'h000;
      next_st.periodTick = 1'b1;
    end else begin
      next_st.periodCount = st.periodCount + 11'h001;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st <= '0;
      st.selftestControl <= SELFTEST_CONTROL_RESET;
      st.converterConfig <= CONVERTER_CONFIG_RESET;
      st.pulseConfig <= PULSE_CONFIG_RESET; // RULE14 RULE15
      st.seqState <= SEQ_IDLE;
      st.seqSlot <= LAST_SLOT;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign regReadData = st.readData;

  // the self-test bit overrides the comparator so the fault path downstream is exercised for real
  assign comparatorFault.saturation = st.compStable.saturation
    | st.selftestControl[SATURATION_DETECT_SELFTEST_BIT]; // RULE1
  assign comparatorFault.shortCircuit = st.compStable.shortCircuit
    | st.selftestControl[SHORT_CIRCUIT_SELFTEST_BIT]; // RULE2
  assign comparatorFault.overcurrent = st.compStable.overcurrent
    | st.selftestControl[OVERCURRENT_SELFTEST_BIT]; // RULE3
  assign comparatorFault.clockMonitor = st.compStable.clockMonitor
    | st.selftestControl[SECONDARY_CLOCK_MONITOR_SELFTEST_BIT]; // RULE7
  assign comparatorFault.switchThermal = st.compStable.switchThermal
    | st.selftestControl[SWITCH_THERMAL_SELFTEST_BIT]; // RULE9
  assign secondaryConfigIntegrityFault = st.selftestControl[SECONDARY_CONFIG_INTEGRITY_CHECK_BIT]
    & configIntegrityMismatch; // RULE8
  assign gateThresholdMeasureRun = st.selftestControl[GATE_THRESHOLD_MEASURE_RUN_BIT] & inConfig2; // RULE6

  assign convRequest = (st.seqState == SEQ_CONVERT);
  assign convSlot = st.seqSlot;
  assign convResults = st.results;

  assign overtempEnable = st.pulseConfig[OVERTEMP_ENABLE_LSB +: 3]; // RULE14
  assign overcurrentEnable = st.pulseConfig[OVERCURRENT_ENABLE_LSB +: 3]; // RULE15
  assign pulseOutputFrequency = st.pulseConfig[PULSE_OUTPUT_FREQUENCY_LSB +: 2];
  assign pulseOutputActive = lowFound;
  assign pulseOutputSource = lowSource;
  assign pulsePeriodTick = st.periodTick;

endmodule
